// *** bench/qdcc_host.sv ***
// Host serial port model that writes 24-bit frames to the DAC core.
// Assumes it shares core_clk with the bench and moves only after edges.
`timescale 1ns/1ps
module qdcc_host
(
  input  wire logic core_clk,
  input  wire logic serial_out,
  input  wire logic serial_out_oe,
  output logic      sclk,
  output logic      sync_n,
  output logic      serial_in
);
  // Link clock idles high and stands still between frames.
  initial
  begin
    sclk      = 1'b1;
    sync_n    = 1'b1;
    serial_in = 1'b0;
  end

  // Waits a number of core clock edges.
  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wait_clk

  // Sends nbits of w msb first, collects serial_out before each fall.
  task automatic send(input logic [23:0] w, input int nbits,
                      output logic [23:0] rd, output logic oe_seen);
    rd      = '0;
    oe_seen = 1'b1;
    sync_n    <= 1'b0;
    serial_in <= w[23];
    for (int i = 0; i < nbits; i++)
    begin
      // The core needs four clocks to show a bit after a rise, so the
      // high phase is five clocks and the sample is taken settled.
      wait_clk(5);
      rd[23-i] = serial_out;
      oe_seen  = oe_seen & serial_out_oe;
      sclk <= 1'b0;
      wait_clk(3);
      sclk <= 1'b1;
      // After the last bit the line shows the inverse, not a held value.
      serial_in <= (i < nbits - 1) ? w[22-i] : ~w[23-i];
    end
    wait_clk(4);
    sync_n <= 1'b1;
    wait_clk(8);
  endtask : send
endmodule : qdcc_host

// *** bench/quad_dac_command_control_tb_top.sv ***
// Self-checking bench for the quad DAC command interpreter.
// Assumes the host model drives the link and the bench the other pins.
`timescale 1ns/1ps
module quad_dac_command_control_tb_top;
  import qdcc_pkg::*;
  logic        core_clk, rst, load_strobe_n, reset_n, clear_level_select;
  wire         sclk, sync_n, serial_in, serial_out, serial_out_oe;
  wire         chain_mode_enable;
  wire  [39:0] dac_codes;
  wire  [7:0]  modes;
  wire  [3:0]  mask;
  int          n_mismatch, check_count;
  logic [9:0]  inp [4];  // Expected input registers.
  logic [9:0]  dac [4];  // Expected DAC registers.
  logic [3:0]  msk;      // Expected strobe mask.
  logic [23:0] rd;
  logic        oe;

  qdcc_core DUT (.core_clk(core_clk), .rst(rst), .sclk(sclk),
    .sync_n(sync_n), .serial_in(serial_in),
    .load_strobe_n(load_strobe_n), .reset_n(reset_n),
    .clear_level_select(clear_level_select), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .dac_codes(dac_codes),
    .channel_power_down_modes(modes), .load_strobe_mask(mask),
    .chain_mode_enable(chain_mode_enable));
  qdcc_host host (.core_clk(core_clk), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .sclk(sclk), .sync_n(sync_n),
    .serial_in(serial_in));

  // 50 MHz core clock.
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Compares one value and counts the result.
  task automatic chk(input string nm, input logic [39:0] e, g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Compares all codes and the mask against the model.
  task automatic chk_all();
    chk("dac_codes", {dac[3], dac[2], dac[1], dac[0]}, dac_codes);
    chk("load_strobe_mask", {36'h0, msk}, {36'h0, mask});
  endtask : chk_all

  // Sends a raw frame of nb bits.
  task automatic frame(input logic [23:0] w, input int nb = 24);
    host.send(w, nb, rd, oe);
  endtask : frame

  // Moves the strobe; a fall copies unmasked input registers.
  task automatic strobe(input logic lvl);
    if (load_strobe_n && !lvl)
      for (int c = 0; c < 4; c++)
        if (!msk[c]) dac[c] = inp[c];
    load_strobe_n <= lvl;
    repeat (6) @(posedge core_clk);
  endtask : strobe

  // Writes a command to the channels in addr and updates the model.
  task automatic wr(input logic [3:0] cmd, addr, input logic [9:0] code);
    frame({cmd, addr, code, 6'h00});
    for (int c = 0; c < 4; c++)
      if (addr[c])
      begin
        if (cmd != CMD_UPD_DAC) inp[c] = code;
        if (cmd != CMD_WR_INPUT || !load_strobe_n) dac[c] = inp[c];
      end
    chk_all();
  endtask : wr

  // Prints the verdict and ends the run.
  task automatic give_verdict();
    if (n_mismatch == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  // Cuts a hang short.
  initial
  begin
    #1ms;
    n_mismatch++;
    give_verdict();
  end

  // Main sequence.
  initial
  begin
    n_mismatch = 0;
    check_count = 0;
    rst = 1'b1;
    reset_n = 1'b0;
    load_strobe_n = 1'b1;
    clear_level_select = 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    foreach (dac[c]) begin dac[c] = CODE_MID; inp[c] = CODE_MID; end
    msk = MASK_RESET;
    chk_all();
    chk("modes", {32'h0, PD_RESET}, {32'h0, modes});
    wr(CMD_WR_UPD, 4'hF, 10'h155);
    strobe(1'b0);
    wr(CMD_WR_INPUT, 4'h3, 10'h3A1);
    strobe(1'b1);
    wr(CMD_WR_INPUT, 4'h2, 10'h0F0);
    strobe(1'b0);
    strobe(1'b1);
    chk_all();
    frame({CMD_LOAD_MASK, 4'hF, 16'h0004});
    msk = 4'h4;
    wr(CMD_WR_INPUT, 4'hC, 10'h2AA);
    strobe(1'b0);
    strobe(1'b1);
    chk_all();
    wr(CMD_UPD_DAC, 4'h4, 10'h000);
    strobe(1'b0);
    wr(CMD_WR_INPUT, 4'h4, 10'h111);
    strobe(1'b1);
    frame({CMD_WR_UPD, 4'hF, 10'h3FF, 6'h00}, 23);
    chk_all();
    frame({CMD_POWER, 4'h0, 16'h00E4});
    chk("modes", 40'hE4, {32'h0, modes});
    wr(CMD_WR_UPD, 4'h8, 10'h0AB);
    // Readback of B, then of A by default with no or several address bits.
    for (int k = 0; k < 3; k++)
    begin
      frame({CMD_READBACK, (k == 0) ? 4'h2 : (k == 1) ? 4'h0 : 4'h3,
             16'h0000});
      chk("oe_idle", 40'h0, {39'h0, oe});
      frame(24'h000000);
      chk("readback", {6'h0, dac[(k == 0) ? 1 : 0]},
          rd[19:4]);
      chk("oe_frame", 40'h1, {39'h0, oe});
      chk("oe_after", 40'h0, {39'h0, serial_out_oe});
    end
    clear_level_select <= 1'b0;
    reset_n <= 1'b0;
    frame({CMD_WR_UPD, 4'hF, 10'h3FF, 6'h00});
    foreach (dac[c]) begin dac[c] = CODE_ZERO; inp[c] = CODE_ZERO; end
    msk = MASK_RESET;
    chk_all();
    chk("modes", 40'h0, {32'h0, modes});
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    frame({CMD_POWER, 4'h0, 16'h0055});
    frame({CMD_LOAD_MASK, 4'h0, 16'h000F});
    msk = 4'hF;
    wr(CMD_WR_UPD, 4'h1, 10'h123);
    wr(CMD_WR_INPUT, 4'h8, 10'h0CC);
    strobe(1'b0);
    strobe(1'b1);
    chk_all();
    frame({CMD_CHAIN, 4'h0, 16'h0001});
    chk("chain_mode_enable", 40'h1, {39'h0, chain_mode_enable});
    chk("oe_chain", 40'h1, {39'h0, serial_out_oe});
    frame({CMD_READBACK, 4'h1, 16'h0000});
    frame(24'hF00000);
    chk("readback", {6'h0, dac[0]}, rd[19:4]);
    frame({CMD_SOFT_RESET, 4'h0, 16'h0000});
    foreach (dac[c]) begin dac[c] = CODE_ZERO; inp[c] = CODE_ZERO; end
    msk = MASK_RESET;
    chk_all();
    chk("modes", 40'h0, {32'h0, modes});
    chk("chain_mode_enable", 40'h0, {39'h0, chain_mode_enable});
    give_verdict();
  end
endmodule : quad_dac_command_control_tb_top

// *** verilog/qdcc_core.sv ***
// Command interpreter of a quad 10-bit DAC behind a 24-bit serial frame.
// Assumes link pins and the load strobe are asynchronous to core_clk,
// and that the link clock is slow enough for edge sampling.
// Summary of operation
// - Frame: command, one-hot address, 10-bit code.
// - Act on frame sync rise after 24.
// - Command 1001 arms readback, default channel A.
// - Next frame shifts chosen register out.
// - First four bits undefined, register at 19:4.
// - Output enabled for the readback frame and in chain mode.
// - Command 0100 loads per-channel power-down bits.
// - Modes: normal, 1k, 100k, three-state.
// - Power-down keeps and permits DAC writes.
// - Strobe low: 0001 updates input and DAC.
// - Strobe high: falling strobe copies unmasked; a fall while a frame shifts in is dropped.
// - Command 0010 copies input into DAC.
// - Command 0011 writes input and DAC.
// - Command 0101 loads the strobe mask.
// - Masked channel sees strobe as high.
// - Strobe tied low ignores the mask.
// - Hardware reset clears to selected level.
// - No output update while reset is low.
// - Command 0110 performs software reset.
// - Strobe ignored during power-on reset.
// - Power-up level chosen by select pin; rst itself always loads CODE_ZERO.
`timescale 1ns/1ps
module qdcc_core
  import qdcc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        sclk,
  input  wire logic        sync_n,
  input  wire logic        serial_in,
  input  wire logic        load_strobe_n,
  input  wire logic        reset_n,
  input  wire logic        clear_level_select,
  output logic             serial_out,
  output logic             serial_out_oe,
  output logic [39:0]      dac_codes,
  output logic [7:0]       channel_power_down_modes,
  output logic [3:0]       load_strobe_mask,
  output logic             chain_mode_enable
);

  // Frame-state machine with one-hot states.
  typedef enum logic [2:0] {
    QDCC_IDLE  = 3'b001,
    QDCC_SHIFT = 3'b010,
    QDCC_DONE  = 3'b100
  } qdcc_state_t;

  // Synchronised pins.
  logic sclk_s;                  // Link clock after two flops.
  logic sync_s;                  // Frame sync after two flops.
  logic din_s;                   // Serial data after two flops.
  logic load_strobe_n_s;                  // Load strobe after two flops.
  logic hwrst_s;                 // Hardware reset after two flops.
  logic sel_s;                   // Clear-level select after two flops.

  // Edge history registers.
  logic sclk_d;                  // Previous link clock sample.
  logic sync_d;                  // Previous frame sync sample.
  logic load_strobe_n_d;                  // Previous load strobe sample.
  logic hwrst_d;                 // Previous hardware reset sample.

  // Decoded edges.
  logic sclk_fall;               // Falling link clock edge.
  logic sclk_rise;               // Rising link clock edge.
  logic frame_start;             // Frame sync falling edge.
  logic frame_end;               // Frame sync rising edge.
  logic load_strobe_n_fall;               // Load strobe falling edge.

  // Frame state.
  qdcc_state_t state;            // Current frame state.
  qdcc_state_t next_state;       // Next frame state.
  logic [23:0] frame_word;       // Shifted-in frame.
  logic [4:0]  bit_count;        // Falling edges seen.
  logic        shift_bit;        // Bit at the head of the out word.
  logic [23:0] load_word;        // Word loaded for output.

  // Register banks, one 10-bit code per channel.
  logic [9:0] input_reg [4];     // Input registers.
  logic [9:0] dac_reg   [4];     // DAC registers.

  // Readback control.
  logic       rb_armed;          // Next frame carries readback data.
  logic       rb_active;         // Current frame is a readback frame.
  logic [1:0] rb_sel;            // Channel chosen for readback.

  // Reset requests.
  logic       soft_rst;          // Software reset pulse.
  logic       por_busy;          // Reset in progress, strobe ignored.
  logic       clear_level;       // Level caught after reset release.

  // Decoded frame fields.
  logic [3:0] cmd;               // Command code.
  logic [3:0] addr;              // One-hot address bits.
  logic [9:0] code;              // Data code.
  logic       frame_ok;          // Full valid frame completed.

  // Returns the readback channel for an address field.
  function automatic logic [1:0] qdcc_pick(input logic [3:0] a);
    case (a)
      4'h2:    qdcc_pick = 2'h1;
      4'h4:    qdcc_pick = 2'h2;
      4'h8:    qdcc_pick = 2'h3;
      default: qdcc_pick = 2'h0;
    endcase
  endfunction : qdcc_pick

  // Synchronisers for every asynchronous pin.
  qdcc_sync u_sync_sclk (.core_clk(core_clk), .rst(rst),
    .async_in(sclk), .reset_value(1'b1), .sync_out(sclk_s));
  qdcc_sync u_sync_sync (.core_clk(core_clk), .rst(rst),
    .async_in(sync_n), .reset_value(1'b1), .sync_out(sync_s));
  qdcc_sync u_sync_din (.core_clk(core_clk), .rst(rst),
    .async_in(serial_in), .reset_value(1'b1), .sync_out(din_s));
  qdcc_sync u_sync_load_strobe_n (.core_clk(core_clk), .rst(rst),
    .async_in(load_strobe_n), .reset_value(1'b1), .sync_out(load_strobe_n_s));
  qdcc_sync u_sync_hwrst (.core_clk(core_clk), .rst(rst),
    .async_in(reset_n), .reset_value(1'b1), .sync_out(hwrst_s));
  qdcc_sync u_sync_sel (.core_clk(core_clk), .rst(rst),
    .async_in(clear_level_select), .reset_value(1'b1),
    .sync_out(sel_s));

  // Edge history on the synchronised pins.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sclk_d  <= 1'b1;
      sync_d  <= 1'b1;
      load_strobe_n_d  <= 1'b1;
      hwrst_d <= 1'b1;
    end
    else
    begin
      sclk_d  <= sclk_s;
      sync_d  <= sync_s;
      load_strobe_n_d  <= load_strobe_n_s;
      hwrst_d <= hwrst_s;
    end
  end

  assign sclk_fall   = sclk_d & ~sclk_s;
  assign sclk_rise   = ~sclk_d & sclk_s;
  assign frame_start = sync_d & ~sync_s;
  assign frame_end   = ~sync_d & sync_s;
  assign load_strobe_n_fall   = load_strobe_n_d & ~load_strobe_n_s;

  // Frame fields, msb first.
  assign cmd  = frame_word[CMD_MSB:CMD_LSB];
  assign addr = frame_word[ADDR_MSB:ADDR_LSB];
  assign code = frame_word[CODE_MSB:CODE_LSB];
  assign frame_ok = frame_end && state == QDCC_SHIFT &&
                    bit_count == 5'd24;

  // Frame state machine.
  always_comb
  begin
    next_state = state;
    case (state)
      QDCC_IDLE:  if (frame_start) next_state = QDCC_SHIFT;
      QDCC_SHIFT: if (frame_end) next_state = QDCC_DONE;
      QDCC_DONE:  next_state = QDCC_IDLE;
      default:    next_state = QDCC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= QDCC_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Readback data: four undefined bits, then the register at 19:4.
  assign load_word = {4'h0, 6'h00, dac_reg[rb_sel], 4'h0};

  // Serial shifter.
  qdcc_shift u_shift (
    .core_clk    (core_clk),
    .rst         (rst),
    .sclk_fall   (sclk_fall),
    .sclk_rise   (sclk_rise),
    .frame_start (frame_start),
    .frame_active(state == QDCC_SHIFT),
    .data_in     (din_s),
    .load_word   (load_word),
    .frame_word  (frame_word),
    .bit_count   (bit_count),
    .out_bit     (shift_bit)
  );

  // Reset in progress: held hardware reset or soft reset.
  assign por_busy = ~hwrst_s | soft_rst;

  // Clear level caught on the clock after reset and on held reset.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      clear_level <= 1'b0;
    end
    else if (~hwrst_s || soft_rst || state == QDCC_IDLE && !rb_armed
             && clear_level != sel_s && hwrst_d == 1'b0)
    begin
      clear_level <= sel_s;
    end
  end

  // Software reset pulse from command 0110.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      soft_rst <= 1'b0;
    end
    else
    begin
      soft_rst <= frame_ok && cmd == CMD_SOFT_RESET;
    end
  end

  // Input and DAC registers.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 4; i++)
      begin
        input_reg[i] <= CODE_ZERO;
        dac_reg[i]   <= CODE_ZERO;
      end
    end
    else if (por_busy)
    begin
      // Clear to the selected level; no new value accepted.
      for (int i = 0; i < 4; i++)
      begin
        input_reg[i] <= sel_s ? CODE_MID : CODE_ZERO;
        dac_reg[i]   <= sel_s ? CODE_MID : CODE_ZERO;
      end
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (frame_ok && addr[i] && cmd == CMD_WR_INPUT)
        begin
          input_reg[i] <= code;
          if (!load_strobe_n_s)
          begin
            dac_reg[i] <= code;
          end
        end
        else if (frame_ok && addr[i] && cmd == CMD_WR_UPD)
        begin
          input_reg[i] <= code;
          dac_reg[i]   <= code;
        end
        else if (frame_ok && addr[i] && cmd == CMD_UPD_DAC)
        begin
          dac_reg[i] <= input_reg[i];
        end
        else if (load_strobe_n_fall && !load_strobe_mask[i] && state != QDCC_SHIFT)
        begin
          dac_reg[i] <= input_reg[i];
        end
      end
    end
  end

  // Power-down modes, strobe mask and chain enable.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      channel_power_down_modes <= PD_RESET;
      load_strobe_mask         <= MASK_RESET;
      chain_mode_enable        <= 1'b0;
    end
    else if (por_busy)
    begin
      channel_power_down_modes <= PD_RESET;
      load_strobe_mask         <= MASK_RESET;
      chain_mode_enable        <= 1'b0;
    end
    else if (frame_ok)
    begin
      case (cmd)
        CMD_POWER:     channel_power_down_modes <=
                         frame_word[PD_MSB:0];
        CMD_LOAD_MASK: load_strobe_mask <=
                         frame_word[MASK_MSB:0];
        CMD_CHAIN:     chain_mode_enable <= frame_word[CHAIN_BIT];
        default:       ;
      endcase
    end
  end

  // Readback arming and the readback frame flag.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rb_armed  <= 1'b0;
      rb_active <= 1'b0;
      rb_sel    <= RB_SEL_RESET;
    end
    else if (por_busy)
    begin
      rb_armed  <= 1'b0;
      rb_active <= 1'b0;
      rb_sel    <= RB_SEL_RESET;
    end
    else
    begin
      if (frame_start)
      begin
        rb_active <= rb_armed;
      end
      else if (frame_end)
      begin
        rb_active <= 1'b0;
      end
      if (frame_ok && cmd == CMD_READBACK)
      begin
        rb_armed <= 1'b1;
        rb_sel   <= qdcc_pick(addr);
      end
      else if (frame_ok)
      begin
        rb_armed <= 1'b0;
      end
    end
  end

  // Output drive: chain mode, or forced on for a readback frame.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
    end
    else
    begin
      serial_out    <= shift_bit;
      serial_out_oe <= chain_mode_enable || rb_active;
    end
  end

  // Outputs of the DAC registers.
  always_comb
  begin
    dac_codes = {dac_reg[3], dac_reg[2], dac_reg[1], dac_reg[0]};
  end

  // Hardware reset lasts at least one clock when the host keeps 30 ns.
  AST_NO_UPDATE_IN_RESET:
    assert property (@(posedge core_clk) disable iff (rst)
      !hwrst_s |=> dac_codes == {4{clear_level ? CODE_MID : CODE_ZERO}}
        || $past(sel_s) != clear_level)
    else $error("DAC updated while hardware reset low");

  AST_WRITE_UPDATE:
    assert property (@(posedge core_clk) disable iff (rst)
      frame_ok && cmd == CMD_WR_UPD && addr[0] && !por_busy
      |=> dac_reg[0] == $past(code))
    else $error("Command 0011 did not update DAC A");

  AST_STROBE_LOW_WRITE:
    assert property (@(posedge core_clk) disable iff (rst)
      frame_ok && cmd == CMD_WR_INPUT && addr[1] && !load_strobe_n_s && !por_busy
      |=> dac_reg[1] == $past(code) && input_reg[1] == $past(code))
    else $error("Strobe-low write missed DAC B");

  AST_STROBE_HIGH_HOLD:
    assert property (@(posedge core_clk) disable iff (rst)
      frame_ok && cmd == CMD_WR_INPUT && addr[2] && load_strobe_n_s && !por_busy
      && !load_strobe_n_fall |=> $stable(dac_reg[2]))
    else $error("Strobe-high write changed DAC C");

  AST_MASK_BLOCKS:
    assert property (@(posedge core_clk) disable iff (rst)
      load_strobe_n_fall && load_strobe_mask[3] && !frame_ok && !por_busy
      |=> $stable(dac_reg[3]))
    else $error("Masked channel followed strobe");

  AST_READBACK_SEL:
    assert property (@(posedge core_clk) disable iff (rst)
      frame_ok && cmd == CMD_READBACK && addr == 4'h3 && !por_busy
      |=> rb_sel == 2'h0 && rb_armed)
    else $error("Readback default channel wrong");

  AST_POWER_LOAD:
    assert property (@(posedge core_clk) disable iff (rst)
      frame_ok && cmd == CMD_POWER && !por_busy
      |=> channel_power_down_modes == $past(frame_word[7:0]))
    else $error("Power-down modes not loaded");

  AST_SOFT_RESET:
    assert property (@(posedge core_clk) disable iff (rst)
      frame_ok && cmd == CMD_SOFT_RESET
      |=> ##1 channel_power_down_modes == PD_RESET
        && load_strobe_mask == MASK_RESET)
    else $error("Software reset did not restore state");

  AST_OE_READBACK:
    assert property (@(posedge core_clk) disable iff (rst)
      rb_active && !chain_mode_enable |=> serial_out_oe)
    else $error("Output not enabled for readback frame");

endmodule : qdcc_core

// *** verilog/qdcc_pkg.sv ***
// Package of constants for the quad DAC command interpreter.
// Assumes a 50 MHz core clock that samples the serial link pins.
package qdcc_pkg;

  // Frame layout.
  localparam int FRAME_BITS     = 24;
  localparam int CMD_MSB        = 23;
  localparam int CMD_LSB        = 20;
  localparam int ADDR_MSB       = 19;
  localparam int ADDR_LSB       = 16;
  localparam int CODE_MSB       = 15;
  localparam int CODE_LSB       = 6;
  localparam int CODE_W         = 10;
  localparam int PD_MSB         = 7;
  localparam int MASK_MSB       = 3;
  localparam int CHAIN_BIT      = 0;
  // Readback places the 16-bit register field at frame bits 19:4.
  localparam int RB_FIELD_LSB   = 4;

  // Command codes.
  localparam logic [3:0] CMD_NOP        = 4'h1 - 4'h1;
  localparam logic [3:0] CMD_WR_INPUT   = 4'h1;
  localparam logic [3:0] CMD_UPD_DAC    = 4'h2;
  localparam logic [3:0] CMD_WR_UPD     = 4'h3;
  localparam logic [3:0] CMD_POWER      = 4'h4;
  localparam logic [3:0] CMD_LOAD_MASK  = 4'h5;
  localparam logic [3:0] CMD_SOFT_RESET = 4'h6;
  localparam logic [3:0] CMD_CHAIN      = 4'h8;
  localparam logic [3:0] CMD_READBACK   = 4'h9;

  // Reset values.
  localparam logic [9:0] CODE_ZERO      = 10'h000;
  localparam logic [9:0] CODE_MID       = 10'h200;
  localparam logic [7:0] PD_RESET       = 8'h00;
  localparam logic [3:0] MASK_RESET     = 4'h0;
  localparam logic [1:0] RB_SEL_RESET   = 2'h0;

  // Power-down mode encodings.
  localparam logic [1:0] PD_NORMAL      = 2'h0;
  localparam logic [1:0] PD_1K          = 2'h1;
  localparam logic [1:0] PD_100K        = 2'h2;
  localparam logic [1:0] PD_TRISTATE    = 2'h3;

  // Hardware reset minimum low time and its cycle count.
  localparam int CLK_PERIOD_NS  = 20;
  localparam int RESET_MIN_NS   = 30;
  localparam int RESET_MIN_CYC  =
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : qdcc_pkg

// *** verilog/qdcc_shift.sv ***
// Serial frame shifter: samples data on falling link clock edges.
// Assumes synchronised link clock, frame sync and data as inputs.
`timescale 1ns/1ps
module qdcc_shift
  import qdcc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        sclk_fall,
  input  wire logic        sclk_rise,
  input  wire logic        frame_start,
  input  wire logic        frame_active,
  input  wire logic        data_in,
  input  wire logic [23:0] load_word,
  output logic [23:0]      frame_word,
  output logic [4:0]       bit_count,
  output logic             out_bit
);

  // Outgoing word shifted on rising edges, msb first.
  logic [23:0] out_word;

  // Incoming word and falling-edge counter.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      frame_word <= 24'h00_0000;
      bit_count  <= 5'h00;
    end
    else if (frame_start)
    begin
      bit_count <= 5'h00;
    end
    else if (frame_active && sclk_fall)
    begin
      frame_word <= {frame_word[22:0], data_in};
      if (bit_count != 5'd24)
      begin
        bit_count <= bit_count + 5'h01;
      end
    end
  end

  // Outgoing word is loaded at frame start; bit shows on the line.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      out_word <= 24'h00_0000;
    end
    else if (frame_start)
    begin
      out_word <= load_word;
    end
    else if (frame_active && sclk_rise && bit_count != 5'h00)
    begin
      out_word <= {out_word[22:0], 1'b0};
    end
  end

  // The current msb is the bit on the serial output.
  assign out_bit = out_word[23];

endmodule : qdcc_shift

// *** verilog/qdcc_sync.sv ***
// Two-flop synchroniser for one level from outside the core clock.
// Assumes only the second stage is read by other logic.
`timescale 1ns/1ps
module qdcc_sync
  import qdcc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic async_in,
  input  wire logic reset_value,
  output logic      sync_out
);

  // First stage, read only by the second stage.
  logic stage_one;

  // Both stages reset high, the idle level of the active-low pins.
  // Low-idle pins are not edge-detected, so the high start is harmless.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      stage_one <= 1'b1;
      sync_out  <= 1'b1;
    end
    else
    begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

  // The idle input is kept for a clean interface.
  logic unused_reset_value;
  assign unused_reset_value = reset_value;

endmodule : qdcc_sync
